// File: core/adcs_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          converter sequencer.
// Assumes: Registers sit at byte offsets on the plain register port.
// Notes:   Definitions only.
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADCS_OFF_CHAN_RUN 8'h00
`define ADCS_OFF_TRIG_REF 8'h01
`define ADCS_OFF_TIMING 8'h02
`define ADCS_OFF_RES_HIGH 8'h03
`define ADCS_OFF_RES_LOW 8'h04
`define ADCS_OFF_STATUS 8'h05

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ADCS_BIT_ON 0
`define ADCS_BIT_GO 1
`define ADCS_BIT_TRIGSRC 7
`define ADCS_BIT_JUSTIFY 7
`define ADCS_BIT_DONE 0
`define ADCS_BIT_PWRDN 1
`define ADCS_RST_REG 8'h00
`define ADCS_CHAN_RESERVED 5'h1C

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define ADCS_CONV_TADS 11
`define ADCS_GAP_TADS 2
`define ADCS_INSTR_CLKS 4

`endif

// File: core/adcs_pkg.sv
// Purpose: Types shared by the converter sequencer and its users.
// Assumes: Constants live in adcs_cfg.svh.
// Notes:   Nothing here is imported; users write adcs_pkg::name.
package adcs_pkg;

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START_DLY = 3'b001,
      ST_ACQ = 3'b010,
      ST_CONV = 3'b011,
      ST_GAP = 3'b100
   } adcs_state_t;

   // Analog front end controls
   typedef struct packed {
      logic [4:0] channel;
      logic channel_valid;
      logic [1:0] pos_ref;
      logic [1:0] neg_ref;
      logic powered;
      logic sample_connect;
      logic discharge;
      logic converting;
   } adcs_analog_t;

endpackage : adcs_pkg

// File: core/adcs_sequencer.sv
// Purpose: Control logic of a 10-bit successive-approximation converter.
// Assumes: Triggers, sleep, interrupt enable and sample code come from
//          logic on i_mclk; the RC oscillator level is asynchronous.
// Notes:   Registers are read one cycle after the read strobe.
// What this block does
// - On completion clear go, set done flag, load both result bytes.
// - Software clearing go aborts; result bytes keep previous value.
// - Reset returns registers to reset values and ends any conversion.
// - After completion or abort wait two bit periods before acquiring.
// - Discharge the capacitor array after every sample.
// - With RC clock, delay conversion start one instruction cycle.
// - Sleep on RC clock: finish, then wake or power down, on bit kept.
// - Sleep on other clock aborts and powers down, on bit kept.
// - Trigger select 0 picks compare unit five, 1 charge-time unit.
// - Selected trigger with converter on sets go like software.
// - Triggers are ignored while converter is off.
// - Module disable holds converter in reset and stops its clock.
// - Five-bit channel select routes input; code 11100 reserved.
// - Go reads 1 while busy; write 1 starts, hardware clears.
// - Converter-on bit enables converter; 0 means powered off.
// - Positive reference 00 supply, 01 pin, 10 buffer, 11 supply.
// - Negative reference 00 ground, 01 pin, others ground.
// - Unimplemented control bits read as zero.
// - Acquisition field gives 0,2,4,6,8,12,16,20 bit periods.
// - Clock field divides by 2,8,32,4,16,64; x11 selects RC clock.
// - A full conversion takes eleven bit periods.
// - Justify bit 1 right justifies result, 0 left justifies.
//
// Added by the designer: the strobed register port and the address map.
`include "adcs_cfg.svh"

module adcs_sequencer #(
   parameter int CONV_TADS = `ADCS_CONV_TADS,
   parameter int GAP_TADS = `ADCS_GAP_TADS,
   parameter int INSTR_CLKS = `ADCS_INSTR_CLKS
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // System controls
   input wire logic i_module_disable,
   input wire logic i_sleep,
   input wire logic i_irq_enable,
   output logic o_wake,
   output logic o_done_flag,
   // Trigger sources
   input wire logic i_compare5_trigger,
   input wire logic i_charge_trigger,
   // Dedicated RC oscillator level
   input wire logic i_rc_osc,
   // Analog core
   input wire logic [9:0] i_sample_code,
   output adcs_pkg::adcs_analog_t o_analog
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (CONV_TADS < 1 || CONV_TADS > 31) begin : g_bad_conv
      $error("CONV_TADS must be 1 to 31");
   end
   if (GAP_TADS < 1 || GAP_TADS > 31) begin : g_bad_gap
      $error("GAP_TADS must be 1 to 31");
   end
   if (INSTR_CLKS < 1 || INSTR_CLKS > 31) begin : g_bad_instr
      $error("INSTR_CLKS must be 1 to 31");
   end

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic rst;
   logic [4:0] chan_ff;
   logic go_ff;
   logic on_ff;
   logic trig_src_ff;
   logic [1:0] pref_ff;
   logic [1:0] nref_ff;
   logic justify_ff;
   logic [2:0] acqt_ff;
   logic [2:0] clk_sel_ff;
   logic [7:0] res_high_ff;
   logic [7:0] res_low_ff;
   logic done_ff;
   logic pwrdn_ff;
   logic wake_ff;
   logic [7:0] rdata_ff;
   adcs_pkg::adcs_state_t state_ff;
   adcs_pkg::adcs_state_t nxt_state;
   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;
   logic [5:0] div_ff;
   logic [2:0] rc_sync_ff;
   logic rc_lvl_ff;
   logic [4:0] nxt_chan;
   logic nxt_go;
   logic nxt_on;
   logic nxt_done;
   logic nxt_pwrdn;
   logic [7:0] nxt_res_high;
   logic [7:0] nxt_res_low;
   logic [7:0] nxt_rdata;
   logic [5:0] nxt_div;

   wire wr_chan = i_wr && (i_addr == `ADCS_OFF_CHAN_RUN);
   wire wr_trig = i_wr && (i_addr == `ADCS_OFF_TRIG_REF);
   wire wr_timing = i_wr && (i_addr == `ADCS_OFF_TIMING);
   wire wr_high = i_wr && (i_addr == `ADCS_OFF_RES_HIGH);
   wire wr_low = i_wr && (i_addr == `ADCS_OFF_RES_LOW);
   wire wr_status = i_wr && (i_addr == `ADCS_OFF_STATUS);

   // Module disable holds every register but the RC synchroniser and accepted level at its reset value
   assign rst = i_reset || i_module_disable;

   // ----------------------------------------------------------------------
   // Conversion clock selection
   // ----------------------------------------------------------------------
   // x11 codes pick the RC oscillator; the rest divide the system clock
   wire rc_sel = (clk_sel_ff[1:0] == 2'b11);
   wire [6:0] div_len =
      (clk_sel_ff == 3'h0) ? 7'h02 :
      (clk_sel_ff == 3'h1) ? 7'h08 :
      (clk_sel_ff == 3'h2) ? 7'h20 :
      (clk_sel_ff == 3'h4) ? 7'h04 :
      (clk_sel_ff == 3'h5) ? 7'h10 : 7'h40;
   wire div_tick = ({1'b0, div_ff} == div_len - 7'h01);

   // RC level passes three flops; a change counts once two and three agree
   wire rc_stable = (rc_sync_ff[1] == rc_sync_ff[2]);
   wire rc_tick = rc_stable && rc_sync_ff[2] && !rc_lvl_ff;

   // Bit period strobe; no clock reaches the sequencer while disabled
   wire tad_tick = !i_module_disable &&
      (rc_sel ? rc_tick : div_tick);

   // Divider restarts while idle so the first period is whole
   always_comb begin
      if (state_ff == adcs_pkg::ST_IDLE || div_tick ||
          nxt_state != state_ff) begin
         nxt_div = 6'h00;
      end else begin
         nxt_div = div_ff + 6'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Acquisition length lookup
   // ----------------------------------------------------------------------
   wire [4:0] acq_tads =
      (acqt_ff == 3'h0) ? 5'h00 :
      (acqt_ff == 3'h1) ? 5'h02 :
      (acqt_ff == 3'h2) ? 5'h04 :
      (acqt_ff == 3'h3) ? 5'h06 :
      (acqt_ff == 3'h4) ? 5'h08 :
      (acqt_ff == 3'h5) ? 5'h0C :
      (acqt_ff == 3'h6) ? 5'h10 : 5'h14;

   // ----------------------------------------------------------------------
   // Triggers and go flag
   // ----------------------------------------------------------------------
   wire hw_trig = trig_src_ff ? i_charge_trigger
                              : i_compare5_trigger;
   // Only a powered converter with go clear accepts a trigger
   wire trig_ok = hw_trig && on_ff && !go_ff
      && !pwrdn_ff;
   wire sw_go = wr_chan && i_wdata[`ADCS_BIT_GO] && on_ff && !pwrdn_ff;
   wire busy = (state_ff == adcs_pkg::ST_START_DLY) ||
      (state_ff == adcs_pkg::ST_ACQ) || (state_ff == adcs_pkg::ST_CONV);
   wire last_tad = tad_tick && (cnt_ff == 5'h00);
   wire conv_done = (state_ff == adcs_pkg::ST_CONV) && go_ff && last_tad;
   wire sleep_abort = i_sleep && !rc_sel && (busy || go_ff);
   wire sleep_off = conv_done && i_sleep && rc_sel && !i_irq_enable;
   wire sleep_wake = conv_done && i_sleep && rc_sel && i_irq_enable;

   // Completion and sleep abort win; a trigger wins over a software zero
   always_comb begin
      if (conv_done || sleep_abort || !on_ff) begin
         nxt_go = 1'b0;
      end else if (trig_ok || sw_go) begin
         nxt_go = 1'b1;
      end else if (wr_chan) begin
         nxt_go = go_ff && i_wdata[`ADCS_BIT_GO];
      end else begin
         nxt_go = go_ff;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer state machine
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         adcs_pkg::ST_IDLE: begin
            if (go_ff && on_ff && !pwrdn_ff) begin
               if (rc_sel) begin
                  nxt_state = adcs_pkg::ST_START_DLY;
                  nxt_cnt = 5'(INSTR_CLKS - 1);
               end else if (acq_tads == 5'h00) begin
                  nxt_state = adcs_pkg::ST_CONV;
                  nxt_cnt = 5'(CONV_TADS - 1);
               end else begin
                  nxt_state = adcs_pkg::ST_ACQ;
                  nxt_cnt = acq_tads - 5'h01;
               end
            end
         end
         adcs_pkg::ST_START_DLY: begin
            if (!go_ff || sleep_abort) begin
               nxt_state = adcs_pkg::ST_GAP;
               nxt_cnt = 5'(GAP_TADS - 1);
            end else if (cnt_ff != 5'h00) begin
               nxt_cnt = cnt_ff - 5'h01;
            end else if (acq_tads == 5'h00) begin
               nxt_state = adcs_pkg::ST_CONV;
               nxt_cnt = 5'(CONV_TADS - 1);
            end else begin
               nxt_state = adcs_pkg::ST_ACQ;
               nxt_cnt = acq_tads - 5'h01;
            end
         end
         adcs_pkg::ST_ACQ: begin
            if (!go_ff || sleep_abort) begin
               nxt_state = adcs_pkg::ST_GAP;
               nxt_cnt = 5'(GAP_TADS - 1);
            end else if (last_tad) begin
               nxt_state = adcs_pkg::ST_CONV;
               nxt_cnt = 5'(CONV_TADS - 1);
            end else if (tad_tick) begin
               nxt_cnt = cnt_ff - 5'h01;
            end
         end
         adcs_pkg::ST_CONV: begin
            if (!go_ff || sleep_abort || conv_done) begin
               nxt_state = adcs_pkg::ST_GAP;
               nxt_cnt = 5'(GAP_TADS - 1);
            end else if (tad_tick) begin
               nxt_cnt = cnt_ff - 5'h01;
            end
         end
         adcs_pkg::ST_GAP: begin
            if (last_tad || !on_ff) begin
               nxt_state = adcs_pkg::ST_IDLE;
               nxt_cnt = 5'h00;
            end else if (tad_tick) begin
               nxt_cnt = cnt_ff - 5'h01;
            end
         end
         default: begin
            nxt_state = adcs_pkg::ST_IDLE;
            nxt_cnt = 5'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Results, flags and power-down
   // ----------------------------------------------------------------------
   // Result bytes load on completion, formatted by the justify bit, or from register writes
   always_comb begin
      nxt_res_high = res_high_ff;
      nxt_res_low = res_low_ff;
      if (conv_done && justify_ff) begin
         nxt_res_high = {6'h00, i_sample_code[9:8]};
         nxt_res_low = i_sample_code[7:0];
      end else if (conv_done) begin
         nxt_res_high = i_sample_code[9:2];
         nxt_res_low = {i_sample_code[1:0], 6'h00};
      end else begin
         if (wr_high) begin
            nxt_res_high = i_wdata;
         end
         if (wr_low) begin
            nxt_res_low = i_wdata;
         end
      end
   end

   // Done flag: set beats a write-one-to-clear in the same cycle
   assign nxt_done = conv_done ||
      (done_ff && !(wr_status && i_wdata[`ADCS_BIT_DONE]));

   // Power-down keeps the on bit but stops the analog core until wake
   assign nxt_pwrdn = i_sleep &&
      (pwrdn_ff || sleep_abort || sleep_off);

   assign nxt_on = wr_chan ? i_wdata[`ADCS_BIT_ON] : on_ff;
   assign nxt_chan = wr_chan ? i_wdata[6:2] : chan_ff;

   // ----------------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------------
   // Unimplemented bits and unmapped offsets read as zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `ADCS_OFF_CHAN_RUN: begin
               nxt_rdata = {1'b0, chan_ff, go_ff, on_ff};
            end
            `ADCS_OFF_TRIG_REF: begin
               nxt_rdata = {trig_src_ff, 3'h0, pref_ff, nref_ff};
            end
            `ADCS_OFF_TIMING: begin
               nxt_rdata = {justify_ff, 1'b0, acqt_ff, clk_sel_ff};
            end
            `ADCS_OFF_RES_HIGH: begin
               nxt_rdata = res_high_ff;
            end
            `ADCS_OFF_RES_LOW: begin
               nxt_rdata = res_low_ff;
            end
            `ADCS_OFF_STATUS: begin
               nxt_rdata = {6'h00, pwrdn_ff, done_ff};
            end
            default: begin
               nxt_rdata = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Flip-flops
   // ----------------------------------------------------------------------
   // Control and result registers
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         {chan_ff, go_ff, on_ff} <= 7'h00;
         {trig_src_ff, pref_ff, nref_ff} <= 5'h00;
         {justify_ff, acqt_ff, clk_sel_ff} <= 7'h00;
         res_high_ff <= `ADCS_RST_REG;
         res_low_ff <= `ADCS_RST_REG;
      end else begin
         chan_ff <= nxt_chan;
         go_ff <= nxt_go;
         on_ff <= nxt_on;
         if (wr_trig) begin
            {trig_src_ff, pref_ff, nref_ff} <=
               {i_wdata[`ADCS_BIT_TRIGSRC], i_wdata[3:0]};
         end
         if (wr_timing) begin
            {justify_ff, acqt_ff, clk_sel_ff} <=
               {i_wdata[`ADCS_BIT_JUSTIFY], i_wdata[5:0]};
         end
         res_high_ff <= nxt_res_high;
         res_low_ff <= nxt_res_low;
      end
   end

   // Sequencer, flags and read data
   always_ff @(posedge i_mclk) begin
      if (rst) begin
         state_ff <= adcs_pkg::ST_IDLE;
         cnt_ff <= 5'h00;
         div_ff <= 6'h00;
         done_ff <= 1'b0;
         pwrdn_ff <= 1'b0;
         wake_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         div_ff <= nxt_div;
         done_ff <= nxt_done;
         pwrdn_ff <= nxt_pwrdn;
         wake_ff <= sleep_wake;
         rdata_ff <= nxt_rdata;
      end
   end

   // RC oscillator synchroniser and accepted level
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         rc_sync_ff <= 3'h0;
         rc_lvl_ff <= 1'b0;
      end else begin
         rc_sync_ff <= {rc_sync_ff[1:0], i_rc_osc};
         if (rc_stable) begin
            rc_lvl_ff <= rc_sync_ff[2];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_rdata = rdata_ff;
   assign o_wake = wake_ff;
   assign o_done_flag = done_ff;
   assign o_analog.channel = chan_ff;
   assign o_analog.channel_valid =
      (chan_ff != `ADCS_CHAN_RESERVED);
   assign o_analog.pos_ref =
      (pref_ff == 2'b11) ? 2'b00 : pref_ff;
   assign o_analog.neg_ref = nref_ff[1] ? 2'b00 : nref_ff;
   assign o_analog.powered = on_ff && !pwrdn_ff;
   assign o_analog.sample_connect = on_ff && !pwrdn_ff &&
      (state_ff == adcs_pkg::ST_IDLE || state_ff == adcs_pkg::ST_ACQ ||
       state_ff == adcs_pkg::ST_START_DLY);
   assign o_analog.discharge = on_ff &&
      (state_ff == adcs_pkg::ST_GAP);
   assign o_analog.converting = (state_ff == adcs_pkg::ST_CONV);

endmodule : adcs_sequencer

// File: sim/adcs_sequencer_monitor.sv
// Purpose: Port-level assertions for the converter sequencer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to adcs_sequencer at the foot of this file.
module adcs_sequencer_monitor (
   // Clock and resets
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_module_disable,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Status and analog side
   input wire logic o_done_flag,
   input wire adcs_pkg::adcs_analog_t o_analog
);
   default clocking mck @(posedge i_mclk);
   endclocking

   // Register read-back and reset behaviour
   a_chan_bit7: assert property (disable iff (i_reset)
      i_rd && i_addr == 8'h00 |=> o_rdata[7] == 1'b0)
      else $error("channel register bit 7 not zero");
   a_trig_unimpl: assert property (disable iff (i_reset)
      i_rd && i_addr == 8'h01 |=> o_rdata[6:4] == 3'h0)
      else $error("trigger register bits 6 to 4 not zero");
   a_reset_clean: assert property (disable iff (i_reset)
      $fell(i_reset) |-> !o_done_flag && o_rdata == 8'h00
      && !o_analog.powered && !o_analog.converting)
      else $error("state not cleared by reset");
   a_disable_hold: assert property (disable iff (i_reset)
      i_module_disable |=> !o_done_flag && !o_analog.powered
      && !o_analog.converting)
      else $error("converter active while disabled");

   // Conversion sequencing
   a_done_cause: assert property (disable iff (i_reset)
      $rose(o_done_flag) |-> $past(o_analog.converting))
      else $error("done flag set without a conversion");
   a_gap_length: assert property (
      disable iff (i_reset || i_module_disable)
      $rose(o_analog.discharge) |->
      (o_analog.discharge && !o_analog.sample_connect)[*4])
      else $error("discharge gap shorter than two bit periods");
   a_conv_powered: assert property (disable iff (i_reset)
      $rose(o_analog.converting) |-> o_analog.powered)
      else $error("conversion started while unpowered");
   a_off_no_start: assert property (disable iff (i_reset)
      !o_analog.powered |-> ##2 !o_analog.converting)
      else $error("conversion began while converter off");

   // Front-end selections
   a_ref_map: assert property (disable iff (i_reset)
      o_analog.pos_ref != 2'b11 && o_analog.neg_ref[1] == 1'b0)
      else $error("reserved reference code passed through");
   a_chan_valid: assert property (disable iff (i_reset)
      o_analog.channel_valid == (o_analog.channel != 5'h1C))
      else $error("channel valid does not match code");

   // Main scenarios reached
   c_done: cover property ($rose(o_done_flag));
   c_gap: cover property ($rose(o_analog.discharge));
   c_disable: cover property (i_module_disable);
endmodule : adcs_sequencer_monitor

bind adcs_sequencer adcs_sequencer_monitor adcs_sequencer_monitor_inst (
   .i_mclk(i_mclk), .i_reset(i_reset),
   .i_module_disable(i_module_disable), .i_addr(i_addr), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_done_flag(o_done_flag), .o_analog(o_analog));

// File: sim/adcs_trigger_model.sv
// Purpose: Compare unit five and charge-time unit trigger sources.
// Assumes: Both peripherals run on the system clock.
// Notes:   Trigger pulses are one cycle, registered.
module adcs_trigger_model (
   // Clock
   input wire logic i_mclk,
   // Peripheral setup and events
   input wire logic [3:0] i_compare_mode,
   input wire logic i_charge_trig_en,
   input wire logic i_fire_compare,
   input wire logic i_fire_charge,
   // Trigger outputs
   output logic o_compare5_trigger,
   output logic o_charge_trigger
);
   timeunit 1ns;
   timeprecision 1ps;
   // Special event only in mode 1011; charge unit needs its enable
   always_ff @(posedge i_mclk) begin
      o_compare5_trigger <= i_fire_compare && i_compare_mode == 4'hB;
      o_charge_trigger <= i_fire_charge && i_charge_trig_en;
   end
endmodule : adcs_trigger_model

// File: sim/adcs_sequencer_tb_top.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: 125 MHz clock; table rows first, then hand-written cases.
// Notes:   Bit-period timing is judged by differences between runs.
module adcs_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] a;
      logic [7:0] w;
      logic [7:0] r;
      logic [4:0] v;
   } adcs_row_t;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic mdis = 1'b0;
   logic sleep = 1'b0;
   logic irqe = 1'b0;
   logic rc = 1'b0;
   logic [9:0] code = 10'h000;
   logic [3:0] mode = 4'h0;
   logic ten = 1'b0;
   logic fc = 1'b0;
   logic fh = 1'b0;
   logic [7:0] rdata;
   logic done, wake, c5t, cht;
   logic [15:0] last;
   adcs_pkg::adcs_analog_t ana;
   int fails = 0;
   int checks_done = 0;
   int tads [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int divs [7] = '{2, 8, 32, 0, 4, 16, 64};
   // Register rows: address, write, read-back, {valid, pos, neg}
   adcs_row_t rows [10] = '{
      '{8'h00, 8'hFE, 8'h7C, 5'h10}, '{8'h00, 8'hF0, 8'h70, 5'h00},
      '{8'h01, 8'hFF, 8'h8F, 5'h00}, '{8'h01, 8'h0A, 8'h0A, 5'h08},
      '{8'h01, 8'h05, 8'h05, 5'h05}, '{8'h02, 8'hFF, 8'hBF, 5'h05},
      '{8'h03, 8'hA5, 8'hA5, 5'h05}, '{8'h04, 8'h3C, 8'h3C, 5'h05},
      '{8'h07, 8'hFF, 8'h00, 5'h05}, '{8'h00, 8'h04, 8'h04, 5'h15}};
   // Trigger rows: on, select, mode ok, enable, fire charge, go
   logic [5:0] trg [7] = '{6'h0C, 6'h2E, 6'h24, 6'h2D, 6'h3F, 6'h3A, 6'h3C};

   adcs_sequencer adcs_sequencer_inst (.i_mclk(mclk), .i_reset(reset),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
      .o_rdata(rdata), .i_module_disable(mdis), .i_sleep(sleep),
      .i_irq_enable(irqe), .o_wake(wake), .o_done_flag(done),
      .i_compare5_trigger(c5t), .i_charge_trigger(cht), .i_rc_osc(rc),
      .i_sample_code(code), .o_analog(ana));
   adcs_trigger_model adcs_trigger_model_inst (.i_mclk(mclk),
      .i_compare_mode(mode), .i_charge_trig_en(ten), .i_fire_compare(fc),
      .i_fire_charge(fh), .o_compare5_trigger(c5t), .o_charge_trigger(cht));

   // System clock and free-running RC oscillator
   initial forever #4 mclk = ~mclk;
   initial forever #20 rc = ~rc;

   // ----------------------------------------------------------------
   // Bus and checking tasks
   // ----------------------------------------------------------------
   task automatic check(input string n, input logic [15:0] s,
                        input logic [15:0] x);
      checks_done++;
      if (s !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic rdc(input logic [7:0] a, input logic [7:0] x,
                      input string n);
      logic [7:0] d;
      rd(a, d);
      check(n, 16'(d), 16'(x));
   endtask : rdc
   task automatic wait_idle;
      for (int m = 0; m < 400 && ana.sample_connect !== 1'b1; m++)
         @(posedge mclk);
      @(posedge mclk);
   endtask : wait_idle
   function automatic logic [15:0] just(input logic r, input logic [9:0] v);
      return r ? {6'h00, v} : {v, 6'h00};
   endfunction : just
   // One conversion: elapsed cycles to done, then results and status
   task automatic conv(input logic [7:0] c2, output int e);
      logic [7:0] hi;
      logic [7:0] lo;
      wr(8'h02, c2);
      wr(8'h00, 8'h07);
      e = 0;
      while (done !== 1'b1 && e < 3000) begin
         @(posedge mclk);
         #1;
         e++;
      end
      check("wake", 16'(wake), 16'(sleep && irqe));
      rdc(8'h00, 8'h05, "go clear");
      rd(8'h03, hi);
      rd(8'h04, lo);
      last = just(c2[7], code);
      check("result", {hi, lo}, last);
      rdc(8'h05, 8'h01, "done flag");
      wr(8'h05, 8'h01);
      wait_idle();
   endtask : conv
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   // Watchdog cuts a hang short
   initial begin
      #100000;
      fails++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [5:0] t;
      int e;
      int base;
      int x;
      int nm;
      logic [7:0] c2;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      for (int a = 0; a < 6; a++)
         if (a < 3 || a == 5)
            rdc(8'(a), 8'h00, "reset value");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].r, "register");
         check("front end", 16'({ana.channel_valid, ana.pos_ref,
            ana.neg_ref}), 16'(rows[i].v));
      end
      $display("register rows done");
      wr(8'h00, 8'h05);
      wait_idle();
      conv(8'h00, base);
      for (int k = 0; k < 15; k++) begin
         if (k != 11) begin
            c2 = (k < 8) ? {2'b00, 3'(k), 3'b000} : 8'(k - 8);
            c2[7] = k[0];
            x = (k < 8) ? tads[k] * 2 : 11 * (divs[k - 8] - 2);
            nm = (k < 8) ? 2 : divs[k - 8];
            code <= 10'h3A5 - 10'(k);
            conv(c2, e);
            check("timing", 16'(e >= base + x - 2 && e <= base + x + nm),
               16'h0001);
         end
      end
      $display("timing done");
      {sleep, irqe} <= 2'b11;
      conv(8'h83, e);
      {sleep, irqe} <= 2'b00;
      code <= 10'h111;
      wr(8'h02, 8'h06);
      wr(8'h00, 8'h07);
      repeat (40) @(posedge mclk);
      wr(8'h00, 8'h05);
      rdc(8'h00, 8'h05, "abort go");
      rdc(8'h03, last[15:8], "abort high");
      rdc(8'h04, last[7:0], "abort low");
      wait_idle();
      wr(8'h02, 8'h00);
      foreach (trg[j]) begin
         t = trg[j];
         wr(8'h01, {t[4], 7'h00});
         wr(8'h00, {6'h01, 1'b0, t[5]});
         mode <= t[3] ? 4'hB : 4'hA;
         ten <= t[2];
         fc <= !t[1];
         fh <= t[1];
         @(posedge mclk);
         fc <= 1'b0;
         fh <= 1'b0;
         repeat (3) @(posedge mclk);
         rdc(8'h00, {6'h01, t[0], t[5]}, "trigger");
         wr(8'h00, 8'h05);
         wait_idle();
      end
      $display("triggers done");
      wr(8'h02, 8'h06);
      wr(8'h00, 8'h07);
      repeat (20) @(posedge mclk);
      sleep <= 1'b1;
      repeat (3) @(posedge mclk);
      rdc(8'h00, 8'h05, "sleep abort");
      rdc(8'h05, 8'h02, "sleep power");
      sleep <= 1'b0;
      wait_idle();
      wr(8'h00, 8'h07);
      mdis <= 1'b1;
      repeat (2) @(posedge mclk);
      mdis <= 1'b0;
      rdc(8'h00, 8'h00, "disable");
      wr(8'h01, 8'h8F);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rdc(8'h01, 8'h00, "mid reset");
      $display("power and reset done");
      finish_test();
   end
endmodule : adcs_sequencer_tb_top
